/* File: core/spm_pkg.sv */
// Shared constants, types and register map of the amplifier front-panel menu controller.
package spm_pkg;

	// Clock rate and key debounce time.
	localparam int CLK_HZ       = 10_000_000;
	localparam int DEBOUNCE_MS  = 10;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
	// Fault pins only need the synchroniser agreement, one stable cycle.
	localparam int PIN_STABLE_CYC = 1;

	// Key positions in the key vector.
	localparam int NUM_KEYS  = 5;
	localparam int KEY_DOWN  = 0;
	localparam int KEY_LEFT  = 1;
	localparam int KEY_RIGHT = 2;
	localparam int KEY_PLUS  = 3;
	localparam int KEY_MINUS = 4;

	// Fault pin positions in the fault pin vector.
	localparam int NUM_PINS = 4;
	localparam int PIN_VOLT = 0;
	localparam int PIN_CURR = 1;
	localparam int PIN_OT   = 2;
	localparam int PIN_AUX  = 3;

	// Display lines, counted from zero; the last one carries the menu name.
	localparam logic [1:0] LINE_L2   = 2'h1;
	localparam logic [1:0] LINE_L3   = 2'h2;
	localparam logic [1:0] LINE_MENU = 2'h3;
	localparam logic [7:0] CURSOR_CHAR = 8'h3E;

	// Menus, one-hot.
	typedef enum logic [2:0] {
		MENU_OPS    = 3'h1,
		MENU_STATUS = 3'h2,
		MENU_SETUP  = 3'h4
	} spm_menu_t;

	// Items of line 3 of the operations menu.
	localparam logic [2:0] ITEM_UNIT_ID = 3'h0;
	localparam logic [2:0] ITEM_MUTE    = 3'h1;
	localparam logic [2:0] ITEM_ATTEN   = 3'h2;
	localparam logic [2:0] ITEM_LOC     = 3'h3;

	// Item counts per menu line.
	localparam logic [2:0] OPS_L1_ITEMS   = 3'h3;
	localparam logic [2:0] OPS_L2_ITEMS   = 3'h2;
	localparam logic [2:0] OPS_L3_ITEMS   = 3'h4;
	localparam logic [2:0] SETUP_L2_ITEMS = 3'h5;
	localparam logic [2:0] SETUP_L3_ITEMS = 3'h4;
	localparam logic [2:0] ONE_ITEM       = 3'h1;

	// Attenuation range in whole dB.
	localparam logic [4:0] ATTEN_MIN  = 5'h00;
	localparam logic [4:0] ATTEN_MAX  = 5'h14;
	localparam logic [4:0] ATTEN_STEP = 5'h01;

	// Selectable fault enables and thresholds (thresholds share the low indices).
	localparam int NUM_SEL  = 5;
	localparam int SEL_LOW  = 0;
	localparam int SEL_HIGH = 1;
	localparam int SEL_TEMP = 2;
	localparam int SEL_REFL = 3;
	localparam int SEL_AUX  = 4;
	localparam int NUM_THR  = 4;
	localparam logic [7:0] THR_STEP     = 8'h01;
	localparam logic [7:0] THR_TOP      = 8'hFF;
	localparam logic [7:0] THR_BOTTOM   = 8'h00;
	localparam logic [7:0] DEF_LOW_DROP = 8'h0A;
	localparam logic [7:0] DEF_TEMP_C   = 8'h46;

	// Settings kept in nonvolatile storage.
	typedef struct packed {
		logic                      mute;
		logic                      remote;
		logic [4:0]                atten;
		logic [NUM_SEL-1:0]        fault_en;
		logic [NUM_THR-1:0][7:0]   thr;
	} spm_settings_t;
	localparam int SET_W = $bits(spm_settings_t);

	// Register word indices.
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_FAULT_EN = 4'h1;
	localparam logic [3:0] REG_THR_LOW  = 4'h2;
	localparam logic [3:0] REG_THR_HIGH = 4'h3;
	localparam logic [3:0] REG_THR_TEMP = 4'h4;
	localparam logic [3:0] REG_THR_REFL = 4'h5;
	localparam logic [3:0] REG_STATUS   = 4'h6;
	localparam logic [3:0] REG_MEAS     = 4'h7;

	// Field positions.
	localparam int CTRL_MUTE_BIT   = 0;
	localparam int CTRL_REMOTE_BIT = 1;
	localparam int CTRL_ATTEN_LSB  = 8;
	localparam int ST_SUMMARY_BIT  = 0;
	localparam int ST_OT_BIT       = 1;
	localparam int ST_LOW_RF_BIT   = 2;
	localparam int ST_CURSOR_LSB   = 4;
	localparam int ST_MENU_LSB     = 8;
	localparam int MEAS_TEMP_LSB   = 8;
	localparam int MEAS_REFL_LSB   = 16;

endpackage

/* File: core/spm_pin_filter.sv */
// Three-flop synchroniser with stability filter and rising-edge pulse, one per input bit.
`timescale 1ns/1ns
`default_nettype none
module spm_pin_filter
	import spm_pkg::*;
#(
	parameter int W          = 5,
	parameter int STABLE_CYC = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] press
);
	localparam int CW = $clog2(STABLE_CYC + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYC - 1);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);

	typedef struct packed {
		logic [W-1:0]          s1;
		logic [W-1:0]          s2;
		logic [W-1:0]          s3;
		logic [W-1:0]          level;
		logic [W-1:0]          press;
		logic [W-1:0][CW-1:0]  cnt;
	} spm_filt_t;

	spm_filt_t s_r;
	spm_filt_t s_nxt;

	// A change is accepted only after the second and third flops agree for the whole window.
	// The first flop feeds the second and nothing else, keeping metastability out of the logic.
	always_comb begin
		s_nxt       = s_r;
		s_nxt.s1    = pin_in;
		s_nxt.s2    = s_r.s1;
		s_nxt.s3    = s_r.s2;
		s_nxt.press = '0;
		for (int i = 0; i < W; i++) begin
			if (s_r.s2[i] == s_r.s3[i] && s_r.s3[i] != s_r.level[i]) begin
				if (s_r.cnt[i] == CNT_LAST) begin
					s_nxt.level[i] = s_r.s3[i];
					s_nxt.press[i] = s_r.s3[i];
					s_nxt.cnt[i]   = '0;
				end else begin
					s_nxt.cnt[i] = s_r.cnt[i] + CNT_ONE;
				end
			end else begin
				s_nxt.cnt[i] = '0;
			end
		end
	end

	// Synchronous reset to all released.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.level;
	assign press = s_r.press;

	// A press pulse lasts exactly one cycle.
	press_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(press != '0) |=> ((press & $past(press)) == '0))
		else $error("press pulse longer than one cycle");

endmodule
`default_nettype wire

/* File: core/spm_menu_ctrl.sv */
// Front-panel menu, settings store and summary fault logic of the power amplifier.
`timescale 1ns/1ns
`default_nettype none
module spm_menu_ctrl
	import spm_pkg::*;
#(
	parameter logic [7:0] RATED_DBM      = 8'h32,
	parameter int         KEY_STABLE_CYC = DEBOUNCE_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic [NUM_KEYS-1:0] key_n,
	input  wire logic              volt_fault_pin,
	input  wire logic              curr_fault_pin,
	input  wire logic              ot_shutdown_pin,
	input  wire logic              aux_input_pin,
	input  wire logic [7:0]        out_power_dbm,
	input  wire logic [7:0]        refl_power_dbm,
	input  wire logic [7:0]        unit_temp_c,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic              nv_restore_valid,
	input  wire logic [SET_W-1:0]  nv_restore_data,
	output logic      [SET_W-1:0]  nv_store_data,
	output logic                   nv_store_we,
	output logic      [1:0]        cursor_line,
	output logic      [7:0]        cursor_char,
	output logic      [2:0]        menu_sel,
	output logic      [2:0][2:0]   line_items,
	output logic                   status_fault_field,
	output logic                   remote_mode,
	output logic                   summary_fault,
	output logic                   lamp_fault,
	output logic                   lamp_rf_out,
	output logic                   lamp_mute,
	output logic                   lamp_online,
	output logic                   rf_enable,
	output logic      [4:0]        atten_db
);
	// Factory settings; the reflected threshold defaults to rated power.
	localparam spm_settings_t SET_DEFAULT = '{
		mute:     1'b1,
		remote:   1'b0,
		atten:    ATTEN_MIN,
		fault_en: '0,
		thr:      {RATED_DBM, DEF_TEMP_C, RATED_DBM, RATED_DBM - DEF_LOW_DROP}
	};

	typedef struct packed {
		spm_settings_t   set;
		spm_menu_t       menu;
		logic [1:0]      cursor;
		logic [2:0][2:0] items;
		logic            ot_latch;
		logic            low_rf;
		logic            summary;
		logic [31:0]     rdata;
		logic            nv_we;
	} spm_state_t;

	localparam spm_state_t STATE_RESET = '{
		set: SET_DEFAULT, menu: MENU_OPS, cursor: 2'h0, items: '0,
		ot_latch: 1'b0, low_rf: 1'b0, summary: 1'b0, rdata: '0, nv_we: 1'b0
	};

	spm_state_t s_r;
	spm_state_t s_nxt;

	logic [NUM_KEYS-1:0] press;
	logic [NUM_PINS-1:0] pin_lvl;

	// Keys are active low on the panel; a long quiet window rejects contact bounce.
	spm_pin_filter #(
		.W          (NUM_KEYS),
		.STABLE_CYC (KEY_STABLE_CYC)
	) u_keys (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin_in  (~key_n),
		.level   (),
		.press   (press)
	);

	// Fault pins are only synchronised; the auxiliary pin reads high when left open.
	spm_pin_filter #(
		.W          (NUM_PINS),
		.STABLE_CYC (PIN_STABLE_CYC)
	) u_pins (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin_in  ({aux_input_pin, ot_shutdown_pin, curr_fault_pin, volt_fault_pin}),
		.level   (pin_lvl),
		.press   ()
	);

	// Number of selectable items on a line of a menu.
	function automatic logic [2:0] item_count(input spm_menu_t m, input logic [1:0] line);
		logic [2:0] c;
		c = ONE_ITEM;
		unique case (m)
			MENU_OPS: begin
				c = (line == LINE_L3) ? OPS_L3_ITEMS : (line == LINE_L2) ? OPS_L2_ITEMS : OPS_L1_ITEMS;
			end
			MENU_STATUS: begin
				c = ONE_ITEM;
			end
			MENU_SETUP: begin
				c = (line == LINE_L3) ? SETUP_L3_ITEMS : (line == LINE_L2) ? SETUP_L2_ITEMS : ONE_ITEM;
			end
			default: begin
				c = ONE_ITEM;
			end
		endcase
		return c;
	endfunction

	// Keep an attenuation value inside its legal range.
	function automatic logic [4:0] atten_clamp(input logic [4:0] a);
		return (a > ATTEN_MAX) ? ATTEN_MAX : a;
	endfunction

	// Fault conditions compared against the stored thresholds.
	logic       cond_low;
	logic       cond_high;
	logic       cond_hot;
	logic       cond_refl;
	logic [NUM_SEL-1:0] sel_cond;
	logic       fixed_fault;
	assign cond_low  = out_power_dbm < s_r.set.thr[SEL_LOW];
	assign cond_high = out_power_dbm > s_r.set.thr[SEL_HIGH];
	assign cond_hot  = unit_temp_c > s_r.set.thr[SEL_TEMP];
	assign cond_refl = refl_power_dbm > s_r.set.thr[SEL_REFL];
	assign sel_cond  = {pin_lvl[PIN_AUX], cond_refl, cond_hot, cond_high, cond_low};
	assign fixed_fault = pin_lvl[PIN_VOLT] | pin_lvl[PIN_CURR] | s_r.ot_latch;

	// Next-state logic: keys first, then the register port, then a restore, then the shutdown.
	// A restore wins over keys and bus so a power-up reload is never half overwritten.
	always_comb begin
		logic       local_ok;
		logic       plus;
		logic [2:0] it;
		logic [2:0] cnt;
		local_ok = !s_r.set.remote;
		plus     = press[KEY_PLUS];
		it       = s_r.items[s_r.cursor[1:0] == LINE_MENU ? 2'h0 : s_r.cursor];
		cnt      = item_count(s_r.menu, s_r.cursor);
		s_nxt       = s_r;
		s_nxt.nv_we = 1'b0;
		s_nxt.rdata = '0;

		if (press[KEY_DOWN]) begin
			s_nxt.cursor = s_r.cursor + 2'h1;
		end else if (press[KEY_LEFT] || press[KEY_RIGHT]) begin
			if (s_r.cursor == LINE_MENU) begin
				s_nxt.items = '0;
				unique case (s_r.menu)
					MENU_OPS:    s_nxt.menu = press[KEY_RIGHT] ? MENU_STATUS : MENU_SETUP;
					MENU_STATUS: s_nxt.menu = press[KEY_RIGHT] ? MENU_SETUP : MENU_OPS;
					MENU_SETUP:  s_nxt.menu = press[KEY_RIGHT] ? MENU_OPS : MENU_STATUS;
					default:     s_nxt.menu = MENU_OPS;
				endcase
			end else if (press[KEY_RIGHT]) begin
				s_nxt.items[s_r.cursor] = (it >= cnt - 3'h1) ? 3'h0 : it + 3'h1;
			end else begin
				s_nxt.items[s_r.cursor] = (it == 3'h0) ? cnt - 3'h1 : it - 3'h1;
			end
		end else if (plus || press[KEY_MINUS]) begin
			// Only line 3 of operations and lines 2 and 3 of setup hold editable items.
			unique case (s_r.menu)
				MENU_OPS: begin
					if (s_r.cursor == LINE_L3) begin
						if (it == ITEM_MUTE && local_ok) begin
							s_nxt.set.mute = !s_r.set.mute;
						end else if (it == ITEM_ATTEN && local_ok) begin
							if (plus && s_r.set.atten < ATTEN_MAX) begin
								s_nxt.set.atten = s_r.set.atten + ATTEN_STEP;
							end else if (!plus && s_r.set.atten > ATTEN_MIN) begin
								s_nxt.set.atten = s_r.set.atten - ATTEN_STEP;
							end
						end else if (it == ITEM_LOC) begin
							// The location itself stays reachable, else a remote unit could lock out its panel.
							s_nxt.set.remote = !s_r.set.remote;
						end
					end
				end
				MENU_STATUS: begin
					s_nxt.set = s_r.set;
				end
				MENU_SETUP: begin
					if (s_r.cursor == LINE_L2 && local_ok) begin
						s_nxt.set.fault_en[it] = !s_r.set.fault_en[it];
					end else if (s_r.cursor == LINE_L3 && local_ok) begin
						if (plus && s_r.set.thr[it[1:0]] != THR_TOP) begin
							s_nxt.set.thr[it[1:0]] = s_r.set.thr[it[1:0]] + THR_STEP;
						end else if (!plus && s_r.set.thr[it[1:0]] != THR_BOTTOM) begin
							s_nxt.set.thr[it[1:0]] = s_r.set.thr[it[1:0]] - THR_STEP;
						end
					end
				end
				default: begin
					s_nxt.set = s_r.set;
				end
			endcase
		end

		// Register writes: the location bit is always writable, all else only in remote.
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: begin
					s_nxt.set.remote = reg_wdata[CTRL_REMOTE_BIT];
					if (s_r.set.remote) begin
						s_nxt.set.mute  = reg_wdata[CTRL_MUTE_BIT];
						s_nxt.set.atten = atten_clamp(reg_wdata[CTRL_ATTEN_LSB +: 5]);
					end
				end
				REG_FAULT_EN: if (s_r.set.remote) s_nxt.set.fault_en = reg_wdata[NUM_SEL-1:0];
				REG_THR_LOW:  if (s_r.set.remote) s_nxt.set.thr[SEL_LOW] = reg_wdata[7:0];
				REG_THR_HIGH: if (s_r.set.remote) s_nxt.set.thr[SEL_HIGH] = reg_wdata[7:0];
				REG_THR_TEMP: if (s_r.set.remote) s_nxt.set.thr[SEL_TEMP] = reg_wdata[7:0];
				REG_THR_REFL: if (s_r.set.remote) s_nxt.set.thr[SEL_REFL] = reg_wdata[7:0];
				default: s_nxt.set = s_nxt.set;
			endcase
		end

		// Register reads return data in the next cycle only; unmapped words read zero.
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: begin
					s_nxt.rdata[CTRL_MUTE_BIT]        = s_r.set.mute;
					s_nxt.rdata[CTRL_REMOTE_BIT]      = s_r.set.remote;
					s_nxt.rdata[CTRL_ATTEN_LSB +: 5]  = s_r.set.atten;
				end
				REG_FAULT_EN: s_nxt.rdata[NUM_SEL-1:0] = s_r.set.fault_en;
				REG_THR_LOW:  s_nxt.rdata[7:0] = s_r.set.thr[SEL_LOW];
				REG_THR_HIGH: s_nxt.rdata[7:0] = s_r.set.thr[SEL_HIGH];
				REG_THR_TEMP: s_nxt.rdata[7:0] = s_r.set.thr[SEL_TEMP];
				REG_THR_REFL: s_nxt.rdata[7:0] = s_r.set.thr[SEL_REFL];
				REG_STATUS: begin
					s_nxt.rdata[ST_SUMMARY_BIT]     = s_r.summary;
					s_nxt.rdata[ST_OT_BIT]          = s_r.ot_latch;
					s_nxt.rdata[ST_LOW_RF_BIT]      = s_r.low_rf;
					s_nxt.rdata[ST_CURSOR_LSB +: 2] = s_r.cursor;
					s_nxt.rdata[ST_MENU_LSB +: 3]   = s_r.menu;
				end
				REG_MEAS: begin
					s_nxt.rdata[7:0]                = out_power_dbm;
					s_nxt.rdata[MEAS_TEMP_LSB +: 8] = unit_temp_c;
					s_nxt.rdata[MEAS_REFL_LSB +: 8] = refl_power_dbm;
				end
				default: s_nxt.rdata = '0;
			endcase
		end

		// Reload saved settings, muted state included, after power-up.
		if (nv_restore_valid) begin
			s_nxt.set       = nv_restore_data;
			s_nxt.set.atten = atten_clamp(s_nxt.set.atten);
		end

		// Shutdown latches until the unit cools below the user threshold; mute stays on after.
		if (pin_lvl[PIN_OT]) begin
			s_nxt.ot_latch = 1'b1;
		end else if (!cond_hot || unit_temp_c < s_r.set.thr[SEL_TEMP]) begin
			s_nxt.ot_latch = (unit_temp_c < s_r.set.thr[SEL_TEMP]) ? 1'b0 : s_r.ot_latch;
		end
		if (s_nxt.ot_latch) begin
			s_nxt.set.mute = 1'b1;
		end

		s_nxt.low_rf  = cond_low;
		s_nxt.summary = fixed_fault | (|(s_r.set.fault_en & sel_cond));
		s_nxt.nv_we   = (s_nxt.set != s_r.set);
	end

	// All state in one register, synchronous reset to the factory settings.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register; cursor_char is the constant CURSOR_CHAR.
	assign reg_rdata          = s_r.rdata;
	assign nv_store_data      = s_r.set;
	assign nv_store_we        = s_r.nv_we;
	assign cursor_line        = s_r.cursor;
	assign cursor_char        = CURSOR_CHAR;
	assign menu_sel           = s_r.menu;
	assign line_items         = s_r.items;
	assign status_fault_field = s_r.summary;
	assign remote_mode        = s_r.set.remote;
	assign summary_fault      = s_r.summary;
	assign lamp_fault         = s_r.summary;
	assign lamp_rf_out        = !s_r.low_rf;
	assign lamp_mute          = s_r.set.mute;
	assign lamp_online        = !s_r.set.mute;
	assign rf_enable          = !s_r.set.mute;
	assign atten_db           = s_r.set.atten;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Quiet cycle: no bus write, restore or shutdown that could touch settings.
	sequence quiet_s;
		!reg_wr && !nv_restore_valid && !s_r.ot_latch && !pin_lvl[PIN_OT];
	endsequence

	cursor_wrap_a: assert property (press[KEY_DOWN] |=> cursor_line == $past(cursor_line) + 2'h1)
		else $error("down key did not advance the cursor");
	remote_lock_a: assert property ((s_r.set.remote && (press[KEY_PLUS] || press[KEY_MINUS]) ##0 quiet_s)
		|=> (atten_db == $past(atten_db)) && (lamp_mute == $past(lamp_mute)))
		else $error("key changed a setting in remote control");
	mute_toggle_a: assert property ((!s_r.set.remote && s_r.menu == MENU_OPS && s_r.cursor == LINE_L3
		&& s_r.items[LINE_L3] == ITEM_MUTE && press[KEY_MINUS] ##0 quiet_s) |=> lamp_mute != $past(lamp_mute))
		else $error("minus key did not toggle mute");
	atten_step_a: assert property ((!s_r.set.remote && s_r.menu == MENU_OPS && s_r.cursor == LINE_L3
		&& s_r.items[LINE_L3] == ITEM_ATTEN && press[KEY_PLUS] && atten_db < ATTEN_MAX ##0 quiet_s)
		|=> atten_db == $past(atten_db) + ATTEN_STEP)
		else $error("plus key did not raise attenuation by one step");
	atten_range_a: assert property (atten_db <= ATTEN_MAX)
		else $error("attenuation outside range");
	status_ro_a: assert property ((s_r.menu == MENU_STATUS && (press[KEY_PLUS] || press[KEY_MINUS])
		##0 quiet_s) |=> $stable(nv_store_data))
		else $error("status menu changed a setting");
	fixed_fault_a: assert property (pin_lvl[PIN_VOLT] |=> lamp_fault && status_fault_field)
		else $error("voltage fault missing from summary");
	aux_fault_a: assert property ((pin_lvl[PIN_AUX] && s_r.set.fault_en[SEL_AUX]) |=> summary_fault)
		else $error("open auxiliary input not reported");
	low_rf_lamp_a: assert property ((cond_low && $stable(s_r.set.thr[SEL_LOW])) |=> !lamp_rf_out)
		else $error("RF out lamp lit below low threshold");
	ot_mute_a: assert property (pin_lvl[PIN_OT] |=> lamp_mute && !rf_enable ##1 lamp_mute)
		else $error("shutdown did not mute the output");
	menu_step_a: assert property ((cursor_line == LINE_MENU && press[KEY_RIGHT]) |=> menu_sel != $past(menu_sel))
		else $error("menu did not change on line 4");

endmodule
`default_nettype wire

/* File: dv/spm_operator.sv */
// Operator model: presses panel keys and wires the auxiliary fault input.
`timescale 1ns/1ns
`default_nettype none
module spm_operator
	import spm_pkg::*;
#(
	parameter int HOLD = 12
) (
	input  wire logic              clk_sys,
	output logic [NUM_KEYS-1:0] key_n,
	output logic                aux_input_pin
);
	// Keys rest high; a healthy external source grounds the auxiliary line.
	initial begin
		key_n = '1;
		aux_input_pin = 1'b0;
	end
	// One press, held well past the debounce window so it yields one event.
	task automatic press(input int k);
		@(posedge clk_sys);
		key_n[k] <= 1'b0;
		repeat (HOLD) @(posedge clk_sys);
		key_n[k] <= 1'b1;
		repeat (HOLD) @(posedge clk_sys);
		#1;
	endtask
	// Open means fault, ground means healthy.
	task automatic set_aux(input logic open);
		@(posedge clk_sys);
		aux_input_pin <= open;
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_spm_menu_ctrl.sv */
// Self-checking bench of the front-panel menu controller.
`timescale 1ns/1ns
`default_nettype none
module tb_spm_menu_ctrl;
	import spm_pkg::*;
	logic clk_sys, reset_n, volt_fault_pin, curr_fault_pin, ot_shutdown_pin;
	logic reg_wr, reg_rd, nv_restore_valid, nv_store_we, status_fault_field;
	logic remote_mode, summary_fault, lamp_fault, lamp_rf_out, lamp_mute;
	logic lamp_online, rf_enable, aux_input_pin;
	logic [NUM_KEYS-1:0] key_n;
	logic [7:0] out_power_dbm, refl_power_dbm, unit_temp_c, cursor_char;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rdv, seed;
	logic [SET_W-1:0] nv_restore_data, nv_store_data;
	logic [1:0] cursor_line;
	logic [2:0] menu_sel;
	logic [2:0][2:0] line_items;
	logic [4:0] atten_db;
	spm_settings_t sv;
	int n_mismatch, total_checks, m_att, m_low, i;

	spm_menu_ctrl #(.KEY_STABLE_CYC(4)) spm_menu_ctrl_inst (.clk_sys, .reset_n,
		.key_n, .volt_fault_pin, .curr_fault_pin, .ot_shutdown_pin,
		.aux_input_pin, .out_power_dbm, .refl_power_dbm, .unit_temp_c,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.nv_restore_valid, .nv_restore_data, .nv_store_data, .nv_store_we,
		.cursor_line, .cursor_char, .menu_sel, .line_items,
		.status_fault_field, .remote_mode, .summary_fault, .lamp_fault,
		.lamp_rf_out, .lamp_mute, .lamp_online, .rf_enable, .atten_db);
	spm_operator op (.clk_sys, .key_n, .aux_input_pin);

	// Clock of 100 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Compare one result and count it.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		w(1);
	endtask
	// Read data stands only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Watchdog far beyond the expected run of little more than a thousand cycles.
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end

	// Main sequence; the model tracks attenuation and the low threshold.
	initial begin
		{reset_n, volt_fault_pin, curr_fault_pin, ot_shutdown_pin} = '0;
		{reg_wr, reg_rd, nv_restore_valid, reg_addr, reg_wdata} = '0;
		nv_restore_data = '0;
		out_power_dbm = 8'h32;
		refl_power_dbm = 8'h00;
		unit_temp_c = 8'h20;
		seed = 32'd55;
		m_att = 0;
		m_low = 8'h32 - 8'h0A;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		w(6);
		chk(lamp_mute, 1'b1);
		chk(rf_enable, 1'b0);
		chk(atten_db, ATTEN_MIN);
		chk(menu_sel, MENU_OPS);
		chk(cursor_char, CURSOR_CHAR);
		rd(REG_THR_TEMP);
		chk(rdv, DEF_TEMP_C);
		rd(REG_THR_LOW);
		chk(rdv, m_low);
		rd(REG_FAULT_EN);
		chk(rdv, 0);
		rd(4'hE);
		chk(rdv, 0);
		for (i = 1; i <= 6; i++) begin
			op.press(KEY_DOWN);
			chk(cursor_line, i % 4);
		end
		op.press(KEY_RIGHT);
		chk(line_items[2], ITEM_MUTE);
		chk(line_items[0], 0);
		op.press(KEY_PLUS);
		chk(rf_enable, 1'b1);
		chk({lamp_mute, lamp_online}, 2'h1);
		op.press(KEY_MINUS);
		chk(lamp_mute, 1'b1);
		op.press(KEY_RIGHT);
		for (i = 0; i < 22; i++) begin
			op.press(KEY_PLUS);
			m_att = (m_att < 20) ? m_att + 1 : 20;
			chk(atten_db, m_att);
		end
		op.press(KEY_MINUS);
		chk(atten_db, 19);
		op.press(KEY_LEFT);
		op.press(KEY_LEFT);
		chk(line_items[2], ITEM_UNIT_ID);
		wr(REG_CTRL, 32'h1303);
		chk(remote_mode, 1'b1);
		op.press(KEY_RIGHT);
		op.press(KEY_RIGHT);
		op.press(KEY_PLUS);
		chk(atten_db, 19);
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			@(posedge clk_sys);
			out_power_dbm <= seed[7:0];
			w(3);
			chk(lamp_rf_out, out_power_dbm >= m_low);
		end
		out_power_dbm <= 8'h32;
		wr(REG_FAULT_EN, 32'h10);
		op.set_aux(1'b1);
		w(8);
		chk({summary_fault, lamp_fault}, 2'h3);
		chk(status_fault_field, 1'b1);
		op.set_aux(1'b0);
		volt_fault_pin <= 1'b1;
		w(8);
		chk(summary_fault, 1'b1);
		volt_fault_pin <= 1'b0;
		w(8);
		chk({summary_fault, lamp_fault}, 2'h0);
		wr(REG_CTRL, 32'h1302);
		ot_shutdown_pin <= 1'b1;
		unit_temp_c <= 8'h50;
		w(8);
		chk({lamp_mute, summary_fault}, 2'h3);
		ot_shutdown_pin <= 1'b0;
		w(8);
		chk(summary_fault, 1'b1);
		unit_temp_c <= 8'h20;
		w(8);
		chk({lamp_mute, summary_fault}, 2'h2);
		wr(REG_CTRL, 32'h1302);
		wr(REG_FAULT_EN, 32'h04);
		unit_temp_c <= 8'h50;
		w(8);
		chk({summary_fault, rf_enable}, 2'h3);
		sv = '0;
		sv.atten = 5'h1F;
		// Saved thresholds stay legal: high above low, reflected near rated power.
		sv.thr[SEL_LOW] = 8'h28;
		sv.thr[SEL_HIGH] = 8'h32;
		sv.thr[SEL_TEMP] = DEF_TEMP_C;
		sv.thr[SEL_REFL] = 8'h32;
		@(posedge clk_sys);
		nv_restore_data <= sv;
		nv_restore_valid <= 1'b1;
		@(posedge clk_sys);
		nv_restore_valid <= 1'b0;
		#1;
		chk(nv_store_we, 1'b1);
		w(2);
		chk(nv_store_we, 1'b0);
		chk({remote_mode, rf_enable}, 2'h1);
		chk(atten_db, ATTEN_MAX);
		sv.atten = ATTEN_MAX;
		chk(nv_store_data === sv, 1'b1);
		op.press(KEY_DOWN);
		op.press(KEY_RIGHT);
		chk(menu_sel, MENU_STATUS);
		for (i = 0; i < 3; i++) op.press(KEY_DOWN);
		op.press(KEY_MINUS);
		chk({atten_db, rf_enable}, {ATTEN_MAX, 1'b1});
		conclude();
	end
endmodule
`default_nettype wire
